//--- hw/adccfg_pkg.sv
package adccfg_pkg;
	// sfr addresses of the registers this block answers
	localparam logic [7:0] ADDR_SETUP = 8'hbc; // converter_setup
	localparam logic [7:0] ADDR_RES_LOW = 8'hbd; // result_low_byte
	localparam logic [7:0] ADDR_RES_HIGH = 8'hbe; // result_high_byte
	localparam logic [7:0] ADDR_CONTROL = 8'he8; // converter_control
	// indirect gain register addresses
	localparam logic [7:0] GAIN_ADDR_HIGH = 8'h04;
	localparam logic [7:0] GAIN_ADDR_LOW = 8'h07;
	localparam logic [7:0] GAIN_ADDR_EXTRA = 8'h08;
	// reset values
	localparam logic [7:0] SETUP_RESET = 8'hf8;
	localparam logic [7:0] GAIN_HIGH_RESET = 8'hfc;
	localparam logic [3:0] GAIN_LOW_RESET = 4'h0;
	localparam logic EXTRA_GAIN_RESET = 1'b1;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	// converter_setup field positions
	localparam int DIV_MSB = 7;
	localparam int DIV_LSB = 3;
	localparam int RPT_MSB = 2;
	localparam int RPT_LSB = 1;
	localparam int GAIN_EN_BIT = 0;
	// converter_control field positions
	localparam int ENABLE_BIT = 7;
	localparam int BURST_BIT = 6;
	localparam int DONE_BIT = 5;
	localparam int BUSY_BIT = 4;
	localparam int WINDOW_BIT = 3;
	localparam int LJUST_BIT = 2;
	// burst source clock: at most 30 MHz, made from the 100 MHz clock
	localparam int CLK_MHZ = 100;
	localparam int BURST_SRC_MHZ = 30;
	localparam logic [1:0] BURST_PRE_DIV = 2'((CLK_MHZ + BURST_SRC_MHZ - 1) / BURST_SRC_MHZ - 1);
	// conversion clock periods per conversion
	localparam logic [4:0] CONV_PERIODS = 5'd16;
	typedef enum logic [1:0] {ADCCFG_IDLE, ADCCFG_CONV, ADCCFG_WAIT} adccfg_state_t;
endpackage : adccfg_pkg

//--- hw/adccfg_clkdiv.sv
// divides a source enable by field+1 into conversion clock ticks
module adccfg_clkdiv (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic src_tick_i, // one pulse per source clock period
	input wire logic run_i, // restarts the divider while low
	input wire logic [4:0] div_i, // sar_clock_divider field
	output logic tick_o // conversion_clock pulse
);
	logic [4:0] cnt_q; // counts source ticks
	wire cnt_wrap = (cnt_q >= div_i);

	// count source ticks, pulse on wrap
	always_ff @(posedge clk_i) begin
		if (srst_i || !run_i) begin
			cnt_q <= 5'h00;
			tick_o <= 1'b0;
		end else begin
			tick_o <= src_tick_i && cnt_wrap;
			if (src_tick_i) begin
				cnt_q <= cnt_wrap ? 5'h00 : cnt_q + 5'h01;
			end
		end
	end
endmodule // adccfg_clkdiv

//--- hw/adccfg_top.sv
// Overview of operation
// - extra gain bit adds one sixty-fourth gain
// - extra gain at indirect 0x08, bit0 resets one
// - conversion clock equals source over field+1
// - burst off: divider source is system clock
// - burst on: divider source at most 30 MHz
// - repeat field sets 1,4,8,16 conversions
// - normal mode: one start per conversion
// - burst: one start runs all conversions
// - results summed into high/low pair
// - setup bit0 enables gain programming
// - gain enabled: high selects, low loads
// - gain word is high byte plus low nibble
module adccfg_top (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sfr_wr_i, // sfr write strobe
	input wire logic [7:0] sfr_addr_i, // sfr address
	input wire logic [7:0] sfr_wdata_i, // sfr write data
	output logic [7:0] sfr_rdata_o, // registered read data
	input wire logic start_i, // start-of-conversion pulse
	input wire logic [11:0] sample_i, // converter result
	output logic conv_strobe_o, // conversion_clock pulse to the sar
	output logic [11:0] gain_word_o, // twelve-bit gain
	output logic add_sixtyfourth_gain_o, // extra gain bit
	output logic [12:0] gain_scaled_o, // gain in 1/4096 units
	output logic conversion_done_irq_o // accumulation complete
);
	logic [7:0] setup_q; // converter_setup
	logic [7:0] control_q; // converter_control
	logic [7:0] gain_high_q; // gain_word_high
	logic [3:0] gain_low_q; // gain_word_low upper nibble
	logic extra_gain_q; // add_sixtyfourth_gain
	logic [7:0] gain_sel_q; // indirect address
	logic [15:0] acc_q; // accumulated result
	logic [4:0] left_q; // conversions still to run
	logic [4:0] per_q; // conversion clock periods in flight
	logic [1:0] pre_q; // burst source prescaler
	logic src_tick_q; // divider source enable
	logic win_q; // window flag kept by software
	adccfg_pkg::adccfg_state_t state_q;
	wire conv_tick;

	wire [4:0] div_fld = setup_q[adccfg_pkg::DIV_MSB:adccfg_pkg::DIV_LSB];
	wire [1:0] rpt_fld = setup_q[adccfg_pkg::RPT_MSB:adccfg_pkg::RPT_LSB];
	wire gain_en = setup_q[adccfg_pkg::GAIN_EN_BIT];
	wire burst = control_q[adccfg_pkg::BURST_BIT];
	wire enabled = control_q[adccfg_pkg::ENABLE_BIT];
	// repeat code to conversion count
	wire [4:0] rpt_count = (rpt_fld == 2'b00) ? 5'd1 :
		(rpt_fld == 2'b01) ? 5'd4 :
		(rpt_fld == 2'b10) ? 5'd8 : 5'd16;
	wire wr_setup = sfr_wr_i && (sfr_addr_i == adccfg_pkg::ADDR_SETUP);
	wire wr_ctl = sfr_wr_i && (sfr_addr_i == adccfg_pkg::ADDR_CONTROL);
	wire wr_hi = sfr_wr_i && (sfr_addr_i == adccfg_pkg::ADDR_RES_HIGH);
	wire wr_lo = sfr_wr_i && (sfr_addr_i == adccfg_pkg::ADDR_RES_LOW);
	wire gain_load = wr_lo && gain_en;
	wire busy = (state_q != adccfg_pkg::ADCCFG_IDLE);
	wire conv_end = (state_q == adccfg_pkg::ADCCFG_CONV) && conv_tick &&
		(per_q == adccfg_pkg::CONV_PERIODS - 5'd1);
	wire last_conv = conv_end && (left_q == 5'd1);
	wire start_ok = start_i && enabled && !gain_en;
	wire [15:0] acc_sum = acc_q + {4'h0, sample_i};
	// live read value of converter_control
	wire [7:0] ctl_view = {control_q[7:6], conversion_done_irq_o, busy, win_q,
		control_q[adccfg_pkg::LJUST_BIT], control_q[1:0]};
	// justified result view
	wire ljust = control_q[adccfg_pkg::LJUST_BIT];
	wire [7:0] res_hi = ljust ? acc_q[11:4] : acc_q[15:8];
	wire [7:0] res_lo = ljust ? {acc_q[3:0], 4'h0} : acc_q[7:0];
	wire [7:0] rd_mux = (sfr_addr_i == adccfg_pkg::ADDR_SETUP) ? setup_q :
		(sfr_addr_i == adccfg_pkg::ADDR_CONTROL) ? ctl_view :
		(sfr_addr_i == adccfg_pkg::ADDR_RES_HIGH) ? res_hi :
		(sfr_addr_i == adccfg_pkg::ADDR_RES_LOW) ? res_lo : 8'h00;

	// divider source: full clock, or prescaled below 30 MHz in burst
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pre_q <= 2'h0;
			src_tick_q <= 1'b0;
		end else if (!burst) begin
			pre_q <= 2'h0;
			src_tick_q <= 1'b1;
		end else begin
			pre_q <= (pre_q == adccfg_pkg::BURST_PRE_DIV) ? 2'h0 : pre_q + 2'h1;
			src_tick_q <= (pre_q == adccfg_pkg::BURST_PRE_DIV);
		end
	end

	adccfg_clkdiv u_div (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.src_tick_i(src_tick_q),
		.run_i(busy),
		.div_i(div_fld),
		.tick_o(conv_tick)
	);

	// configuration and control registers
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			setup_q <= adccfg_pkg::SETUP_RESET;
			control_q <= adccfg_pkg::CONTROL_RESET;
		end else begin
			if (wr_setup) begin
				setup_q <= sfr_wdata_i;
			end
			if (wr_ctl) begin
				control_q <= sfr_wdata_i;
			end
		end
	end

	// flags: hardware set wins over software clear
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			conversion_done_irq_o <= 1'b0;
			win_q <= 1'b0;
		end else begin
			if (last_conv) begin
				conversion_done_irq_o <= 1'b1;
			end else if (wr_ctl) begin
				conversion_done_irq_o <= sfr_wdata_i[adccfg_pkg::DONE_BIT];
			end
			if (wr_ctl) begin
				win_q <= sfr_wdata_i[adccfg_pkg::WINDOW_BIT];
			end
		end
	end

	// indirect gain registers, write-only
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			gain_sel_q <= 8'h00;
			gain_high_q <= adccfg_pkg::GAIN_HIGH_RESET;
			gain_low_q <= adccfg_pkg::GAIN_LOW_RESET;
			extra_gain_q <= adccfg_pkg::EXTRA_GAIN_RESET;
		end else begin
			if (wr_hi && gain_en) begin
				gain_sel_q <= sfr_wdata_i;
			end
			if (gain_load) begin
				case (gain_sel_q)
					adccfg_pkg::GAIN_ADDR_HIGH: gain_high_q <= sfr_wdata_i;
					adccfg_pkg::GAIN_ADDR_LOW: gain_low_q <= sfr_wdata_i[7:4];
					adccfg_pkg::GAIN_ADDR_EXTRA: extra_gain_q <= sfr_wdata_i[0];
					default: gain_sel_q <= gain_sel_q;
				endcase
			end
		end
	end

	// conversion sequencer and accumulator
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state_q <= adccfg_pkg::ADCCFG_IDLE;
			acc_q <= 16'h0000;
			left_q <= 5'd0;
			per_q <= 5'd0;
		end else begin
			if (wr_hi && !gain_en) begin
				acc_q[15:8] <= sfr_wdata_i;
			end else if (wr_lo && !gain_en) begin
				acc_q[7:0] <= sfr_wdata_i;
			end
			case (state_q)
				adccfg_pkg::ADCCFG_IDLE: begin
					if (start_ok) begin
						acc_q <= 16'h0000;
						left_q <= rpt_count;
						per_q <= 5'd0;
						state_q <= adccfg_pkg::ADCCFG_CONV;
					end
				end
				adccfg_pkg::ADCCFG_CONV: begin
					if (conv_tick) begin
						per_q <= conv_end ? 5'd0 : per_q + 5'd1;
					end
					if (conv_end) begin
						acc_q <= acc_sum;
						left_q <= left_q - 5'd1;
						if (last_conv) begin
							state_q <= adccfg_pkg::ADCCFG_IDLE;
						end else if (burst) begin
							state_q <= adccfg_pkg::ADCCFG_CONV;
						end else begin
							state_q <= adccfg_pkg::ADCCFG_WAIT;
						end
					end
				end
				adccfg_pkg::ADCCFG_WAIT: begin
					if (start_ok || burst) begin
						state_q <= adccfg_pkg::ADCCFG_CONV;
					end
				end
				default: state_q <= adccfg_pkg::ADCCFG_IDLE;
			endcase
		end
	end

	// registered outputs
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sfr_rdata_o <= 8'h00;
			conv_strobe_o <= 1'b0;
			gain_word_o <= {adccfg_pkg::GAIN_HIGH_RESET, adccfg_pkg::GAIN_LOW_RESET};
			add_sixtyfourth_gain_o <= adccfg_pkg::EXTRA_GAIN_RESET;
			gain_scaled_o <= 13'h0000;
		end else begin
			sfr_rdata_o <= rd_mux;
			conv_strobe_o <= conv_tick && (state_q == adccfg_pkg::ADCCFG_CONV);
			gain_word_o <= {gain_high_q, gain_low_q};
			add_sixtyfourth_gain_o <= extra_gain_q;
			// one sixty-fourth is 64 in 1/4096 units
			gain_scaled_o <= {1'b0, gain_high_q, gain_low_q} +
				(extra_gain_q ? 13'h0040 : 13'h0000);
		end
	end
endmodule // adccfg_top

//--- test/adccfg_properties.sv
// watches the top ports; setup_q mirrors converter_setup writes
module adccfg_checker (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic sfr_wr_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic start_i,
	input wire logic [11:0] sample_i,
	input wire logic conv_strobe_o,
	input wire logic [11:0] gain_word_o,
	input wire logic add_sixtyfourth_gain_o,
	input wire logic [12:0] gain_scaled_o,
	input wire logic conversion_done_irq_o
);
	logic [7:0] setup_q; // shadow of converter_setup
	logic clr_w; // software clears the done flag
	logic gwr_w; // gain data write while programming
	assign clr_w = sfr_wr_i && sfr_addr_i == adccfg_pkg::ADDR_CONTROL && !sfr_wdata_i[5];
	assign gwr_w = sfr_wr_i && sfr_addr_i == adccfg_pkg::ADDR_RES_LOW && setup_q[0];
	// follow setup writes
	always_ff @(posedge clk_i) begin
		if (srst_i) setup_q <= adccfg_pkg::SETUP_RESET;
		else if (sfr_wr_i && sfr_addr_i == adccfg_pkg::ADDR_SETUP) setup_q <= sfr_wdata_i;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	a_reset_outs: assert property ($past(srst_i) |-> gain_word_o == 12'hfc0
		&& add_sixtyfourth_gain_o && !conversion_done_irq_o) else $error("bad reset outputs");
	// gain outputs are seen two sampled edges after the low-byte write:
	// one edge loads the gain register, the next one the output flop
	a_word_hold: assert property (!$past(srst_i) && $changed(gain_word_o) |-> $past(gwr_w, 2))
		else $error("gain word moved without write");
	a_extra_hold: assert property (!$past(srst_i) && $changed(add_sixtyfourth_gain_o)
		|-> $past(gwr_w, 2)) else $error("extra gain moved without write");
	// scaled gain and gain word leave their flops on the same edge
	a_scaled_sum: assert property (!$past(srst_i) |-> gain_scaled_o == 13'(gain_word_o)
		+ (add_sixtyfourth_gain_o ? 13'h0040 : 13'h0000)) else $error("scaled gain wrong");
	a_unmapped_zero: assert property (!$past(srst_i) && !$past(sfr_addr_i[7])
		|-> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_setup_read: assert property (!$past(srst_i) && $past(sfr_addr_i) == 8'hbc
		|-> sfr_rdata_o == $past(setup_q)) else $error("setup readback wrong");
	a_irq_clear: assert property ($fell(conversion_done_irq_o) |-> $past(clr_w))
		else $error("done flag fell on its own");
	a_irq_hold: assert property (conversion_done_irq_o && !clr_w |=> conversion_done_irq_o)
		else $error("done flag dropped");
endmodule // adccfg_checker
bind adccfg_top adccfg_checker i_chk (.clk_i(clk_i), .srst_i(srst_i), .sfr_wr_i(sfr_wr_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
	.start_i(start_i), .sample_i(sample_i), .conv_strobe_o(conv_strobe_o),
	.gain_word_o(gain_word_o), .add_sixtyfourth_gain_o(add_sixtyfourth_gain_o),
	.gain_scaled_o(gain_scaled_o), .conversion_done_irq_o(conversion_done_irq_o));

//--- test/adccfg_top_tb.sv
module adccfg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, srst_i = 1, wr = 0, st = 0; // bench-driven controls
	logic [7:0] ad = 8'h00, wd = 8'h00, rdat; // sfr bus
	logic [11:0] gw; // gain word
	logic ga, irq, cs; // extra gain, done flag, strobe
	logic [12:0] gs; // scaled gain
	logic [15:0] v; // read-back value
	logic [11:0] smp = 12'habc; // converter result fed to the block
	int err_total = 0, checks = 0, s, gap, mg; // counters and strobe stats
	adccfg_top i_dut (.clk_i(clk_i), .srst_i(srst_i), .sfr_wr_i(wr), .sfr_addr_i(ad),
		.sfr_wdata_i(wd), .sfr_rdata_o(rdat), .start_i(st), .sample_i(smp),
		.conv_strobe_o(cs), .gain_word_o(gw), .add_sixtyfourth_gain_o(ga),
		.gain_scaled_o(gs), .conversion_done_irq_o(irq));
	initial forever #5 clk_i = ~clk_i;
	task chk(string n, logic [15:0] g, logic [15:0] e);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task give_verdict();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// one sfr write, then a quiet cycle
	task w(logic [7:0] a, logic [7:0] d);
		ad = a;
		wd = d;
		wr = 1;
		@(negedge clk_i) wr = 0;
		@(negedge clk_i);
	endtask
	// read data arrives one cycle after the address
	task r(logic [7:0] a, output logic [7:0] d);
		ad = a;
		@(negedge clk_i) d = rdat;
	endtask
	// gain address then gain data
	task g(logic [7:0] a, logic [7:0] d);
		w(8'hbe, a);
		w(8'hbd, d);
	endtask
	// one cycle, counting strobes and their smallest spacing
	task step();
		@(negedge clk_i);
		gap++;
		if (cs) begin
			s++;
			if (gap < mg) mg = gap;
			gap = 0;
		end
	endtask
	task pulse();
		st = 1;
		step();
		st = 0;
	endtask
	// run one accumulation, normal or burst
	task conv(logic [1:0] rp, logic b, logic [4:0] dv);
		int n, t, tg;
		n = rp ? 2 << rp : 1;
		w(8'hbc, {dv, rp, 1'b0});
		w(8'he8, {1'b1, b, 6'h00});
		s = 0;
		gap = 0;
		mg = 999;
		for (int k = 0; k < (b ? 1 : n); k++) begin
			chk("irq early", irq, 0);
			pulse();
			tg = b ? n * 16 : (k + 1) * 16;
			for (t = 0; t < 3000 && s < tg; t++) step();
			if (t == 3000) begin
				err_total++;
				give_verdict();
			end
			repeat (40) step();
			chk("strobes", 16'(s), 16'(tg));
		end
		chk("spacing", b ? 16'(mg * 3 >= (dv + 1) * 10) : 16'(mg), b ? 16'd1 : 16'(dv + 1));
		chk("irq", irq, 1);
		r(8'hbe, v[15:8]);
		r(8'hbd, v[7:0]);
		chk("sum", v, 16'(n * smp));
		w(8'he8, 8'h80);
		chk("irq clr", irq, 0);
		$display("conv test done");
	endtask
	// main sequence
	initial begin
		repeat (10) @(negedge clk_i);
		srst_i = 0;
		@(negedge clk_i);
		chk("word rst", gw, 16'hfc0);
		chk("extra rst", ga, 1);
		r(8'hbc, v[7:0]);
		chk("setup rst", v[7:0], 8'hf8);
		chk("scaled rst", gs, 16'h1000);
		w(8'hbc, 8'h01);
		w(8'he8, 8'h80);
		s = 0;
		pulse();
		repeat (40) step();
		chk("no conv", 16'(s), 0);
		g(8'h04, 8'h6c);
		g(8'h07, 8'haf);
		g(8'h08, 8'hfe);
		g(8'h05, 8'h00);
		chk("word", gw, 16'h6ca);
		chk("extra", ga, 0);
		chk("scaled", gs, 16'h6ca);
		g(8'h08, 8'h01);
		chk("scaled add", gs, 16'h70a);
		r(8'h00, v[7:0]);
		chk("unmapped", v[7:0], 0);
		$display("gain test done");
		for (int i = 0; i < 4; i++) conv(2'(i), 0, 5'(i));
		smp = 12'h123; // fresh sample value for the slow run
		conv(2'd0, 0, 5'd31);
		// left-justified view of a single result, allowed with one conversion
		w(8'he8, 8'h84);
		r(8'he8, v[7:0]);
		chk("control", v[7:0], 8'h84);
		r(8'hbe, v[15:8]);
		r(8'hbd, v[7:0]);
		chk("left just", v, 16'h1230);
		$display("justify test done");
		conv(2'd3, 1, 5'd0);
		conv(2'd1, 1, 5'd1);
		give_verdict();
	end
endmodule // adccfg_top_tb
